// [hw/lfi_sequencer.sv]
// ring fault isolation sequencer with status and alarm reporting
`timescale 1ns/10ps
module lfi_sequencer
    import lfi_pkg::*;
#(
    parameter longint unsigned HB_PERIOD_CYCLES = HB_PERIOD_CYC,
    parameter int unsigned HB_MISS = HB_MISS_LIMIT,
    parameter longint unsigned DWELL_CYCLES = DWELL_CYC,
    parameter int unsigned TIMEOUT_SECONDS = ISO_TIMEOUT_S,
    parameter longint unsigned SEC_CYCLES = SEC_CYC,
    parameter longint unsigned STATUS_CYCLES = STATUS_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic hb_rx_a,
    input wire logic hb_rx_b,
    input wire logic alarm_change,
    output logic [1:0] iso_open,
    output logic iso_active,
    output logic iso_enabled,
    output logic hb_lost,
    output logic status_send,
    output logic alarm_send,
    input wire logic send_ack
);
    lfi_tick_if ticks ();
    lfi_state_t state_reg;
    logic [31:0] hb_cnt_reg;
    logic [7:0] miss_cnt_reg;
    logic [31:0] dwell_cnt_reg;
    logic [31:0] iso_sec_reg;
    logic iso_en_reg;
    logic [1:0] open_reg;
    logic status_pend_reg;
    logic alarm_pend_reg;
    logic hb_any;
    logic hb_seen;
    logic loss;
    logic dwell_done;
    logic timeout;

    lfi_timer #(
        .SEC_CYCLES(SEC_CYCLES),
        .STATUS_CYCLES(STATUS_CYCLES)
    ) u_timer (
        .clock(clock),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .ticks(ticks.timer)
    );

    // heartbeat is only heard on a port whose switch is closed
    function automatic logic heard(input logic [1:0] open_v, input logic a, input logic b);
        heard = (a && !open_v[PORT_A]) || (b && !open_v[PORT_B]);
    endfunction

    assign hb_any = hb_rx_a || hb_rx_b;
    assign hb_seen = heard(open_reg, hb_rx_a, hb_rx_b);
    assign loss = (miss_cnt_reg >= 8'(HB_MISS));
    assign dwell_done = (dwell_cnt_reg >= 32'(DWELL_CYCLES - 1));
    assign timeout = (iso_sec_reg >= 32'(TIMEOUT_SECONDS));

    // heartbeat period counter, restarted by every heartbeat on a live port
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hb_cnt_reg <= 32'h0;
        end else if (clk_en) begin
            if (hb_seen || hb_cnt_reg >= 32'(HB_PERIOD_CYCLES - 1)) begin
                hb_cnt_reg <= 32'h0;
            end else begin
                hb_cnt_reg <= hb_cnt_reg + 32'h1;
            end
        end
    end

    // count of whole silent periods; saturates at the loss threshold
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            miss_cnt_reg <= 8'h0;
        end else if (clk_en) begin
            if (hb_seen) begin
                miss_cnt_reg <= 8'h0;
            end else if (hb_cnt_reg >= 32'(HB_PERIOD_CYCLES - 1) && !loss) begin
                miss_cnt_reg <= miss_cnt_reg + 8'h1;
            end
        end
    end

    // main isolation state machine
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= LFI_NORMAL;
            open_reg <= 2'h0;
        end else if (clk_en) begin
            unique case (state_reg)
                LFI_NORMAL: begin
                    // closed switches in normal; a break fixed earlier stays open in hold
                    if (loss && iso_en_reg) begin
                        state_reg <= LFI_LISTEN_A;
                        open_reg <= 2'b10;
                    end
                end
                LFI_LISTEN_A, LFI_LISTEN_B: begin
                    if (hb_seen) begin
                        state_reg <= LFI_HOLD;
                    end else if (timeout) begin
                        state_reg <= LFI_NORMAL;
                        open_reg <= 2'b00;
                    end else if (dwell_done) begin
                        // swap which side is cut, never both at once
                        state_reg <= (state_reg == LFI_LISTEN_A) ? LFI_LISTEN_B : LFI_LISTEN_A;
                        open_reg <= ~open_reg;
                    end
                end
                LFI_HOLD: begin
                    // the broken side stays cut; loss again restarts alternation
                    if (loss && iso_en_reg) begin
                        state_reg <= LFI_LISTEN_A;
                        open_reg <= 2'b10;
                    end
                end
            endcase
        end
    end

    // dwell timer per side
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dwell_cnt_reg <= 32'h0;
        end else if (clk_en) begin
            if ((state_reg != LFI_LISTEN_A && state_reg != LFI_LISTEN_B) || dwell_done || hb_seen) begin
                dwell_cnt_reg <= 32'h0;
            end else begin
                dwell_cnt_reg <= dwell_cnt_reg + 32'h1;
            end
        end
    end

    // cumulative isolation seconds; cleared when a heartbeat is found
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            iso_sec_reg <= 32'h0;
        end else if (clk_en) begin
            // a heard beat clears at once, so a held side never carries stale seconds into a restart
            if (state_reg == LFI_NORMAL || state_reg == LFI_HOLD || hb_seen) begin
                iso_sec_reg <= 32'h0;
            end else if (ticks.sec_tick && !timeout) begin
                iso_sec_reg <= iso_sec_reg + 32'h1;
            end
        end
    end

    // routine enable: dropped on timeout, restored by any heartbeat
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            iso_en_reg <= ISO_EN_RESET;
        end else if (clk_en) begin
            if (hb_any) begin
                iso_en_reg <= 1'b1;
            end else if ((state_reg == LFI_LISTEN_A || state_reg == LFI_LISTEN_B) && timeout) begin
                iso_en_reg <= 1'b0;
            end
        end
    end

    // status request raised each period, held until the link acknowledges
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_pend_reg <= 1'b0;
        end else if (clk_en) begin
            if (ticks.status_tick) begin
                status_pend_reg <= 1'b1;
            end else if (send_ack) begin
                status_pend_reg <= 1'b0;
            end
        end
    end

    // alarm request raised at once on a change; a new change wins over the ack
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            alarm_pend_reg <= 1'b0;
        end else if (clk_en) begin
            if (alarm_change) begin
                alarm_pend_reg <= 1'b1;
            end else if (send_ack) begin
                alarm_pend_reg <= 1'b0;
            end
        end
    end

    assign iso_open = open_reg;
    assign iso_active = (state_reg == LFI_LISTEN_A) || (state_reg == LFI_LISTEN_B);
    assign iso_enabled = iso_en_reg;
    assign hb_lost = loss;
    assign status_send = status_pend_reg;
    assign alarm_send = alarm_pend_reg;

    // never both switches open at once
    a_one_side_open: assert property (@(posedge clock) disable iff (!reset_n) open_reg != 2'b11)
        else $error("both isolation switches open");

    // loss while enabled opens port b and listens on port a
    a_loss_starts_iso: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && state_reg == LFI_NORMAL && loss && iso_en_reg |=> state_reg == LFI_LISTEN_A && open_reg == 2'b10)
        else $error("isolation did not start on heartbeat loss");

    a_disabled_no_start: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && state_reg == LFI_NORMAL && !iso_en_reg |=> state_reg == LFI_NORMAL)
        else $error("isolation started while disabled");

    a_dwell_swaps: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && iso_active && dwell_done && !hb_seen && !timeout |=> open_reg == ~$past(open_reg))
        else $error("switches did not alternate after dwell");

    // a beat on the cut port keeps the routine enabled, so only a silent timeout disables
    a_timeout_closes: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && iso_active && timeout && !hb_any |=> open_reg == 2'b00 && !iso_en_reg)
        else $error("timeout did not close switches and disable");

    a_hb_reenables: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && hb_any |=> iso_en_reg)
        else $error("heartbeat did not re-enable isolation");

    a_hb_freezes: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && iso_active && hb_seen |=> state_reg == LFI_HOLD && $stable(open_reg) && iso_sec_reg == 32'h0)
        else $error("heartbeat did not freeze isolation");

    a_status_req: assert property (@(posedge clock) disable iff (!reset_n)
        ticks.status_tick |=> status_send)
        else $error("status report not requested");

    a_alarm_req: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && alarm_change |=> alarm_send)
        else $error("alarm report not requested");

    a_while_dwell: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && iso_active && !dwell_done && !hb_seen && !timeout |=> $stable(open_reg))
        else $error("switch changed before dwell ended");

    // switch pattern follows the state: closed in normal, exactly one side cut otherwise
    a_normal_closed: assert property (@(posedge clock) disable iff (!reset_n)
        state_reg == LFI_NORMAL |-> open_reg == 2'b00)
        else $error("switch open in normal operation");

    a_listen_a_side: assert property (@(posedge clock) disable iff (!reset_n)
        state_reg == LFI_LISTEN_A |-> open_reg == 2'b10)
        else $error("wrong side cut while listening on port a");

    a_listen_b_side: assert property (@(posedge clock) disable iff (!reset_n)
        state_reg == LFI_LISTEN_B |-> open_reg == 2'b01)
        else $error("wrong side cut while listening on port b");

    a_hold_keeps_cut: assert property (@(posedge clock) disable iff (!reset_n)
        state_reg == LFI_HOLD |-> open_reg == 2'b01 || open_reg == 2'b10)
        else $error("hold lost its cut side");

    // a low enable freezes the sequence, so dwell and timeout count only enabled cycles
    a_freeze_holds: assert property (@(posedge clock) disable iff (!reset_n)
        !clk_en |=> $stable(state_reg) && $stable(open_reg) && $stable(dwell_cnt_reg) && $stable(iso_sec_reg))
        else $error("state moved while clock enable low");

    // counters stay inside their ranges; an overrun would stretch a dwell or the timeout
    a_miss_bounded: assert property (@(posedge clock) disable iff (!reset_n)
        miss_cnt_reg <= 8'(HB_MISS))
        else $error("miss count beyond threshold");

    a_dwell_bounded: assert property (@(posedge clock) disable iff (!reset_n)
        dwell_cnt_reg <= 32'(DWELL_CYCLES - 1))
        else $error("dwell count beyond its end");

    a_sec_bounded: assert property (@(posedge clock) disable iff (!reset_n)
        iso_sec_reg <= 32'(TIMEOUT_SECONDS))
        else $error("isolation seconds beyond timeout");

    // a whole silent period adds one miss, a heard beat clears the count
    a_miss_counts: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && !hb_seen && !loss && hb_cnt_reg >= 32'(HB_PERIOD_CYCLES - 1) |=> miss_cnt_reg == $past(miss_cnt_reg) + 8'h1)
        else $error("silent period not counted");

    a_miss_clears: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && hb_seen |=> miss_cnt_reg == 8'h0)
        else $error("heard beat did not clear miss count");

    // the enable drops only on a timeout while alternating
    a_en_drop_timeout: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && iso_en_reg && !(iso_active && timeout) |=> iso_en_reg)
        else $error("routine disabled without timeout");

    // pending reports stand until acknowledged; an ack with no new event clears them
    a_status_holds: assert property (@(posedge clock) disable iff (!reset_n)
        status_send && !send_ack |=> status_send)
        else $error("status report dropped without ack");

    a_alarm_holds: assert property (@(posedge clock) disable iff (!reset_n)
        alarm_send && !send_ack |=> alarm_send)
        else $error("alarm report dropped without ack");

    a_status_acked: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && send_ack && !ticks.status_tick |=> !status_send)
        else $error("status report not cleared by ack");

    a_alarm_acked: assert property (@(posedge clock) disable iff (!reset_n)
        clk_en && send_ack && !alarm_change |=> !alarm_send)
        else $error("alarm report not cleared by ack");
endmodule

// [hw/lfi_pkg.sv]
// constants and types shared by the ring isolation sequencer
//
// Contract
// - the node drives two isolation switch outputs, one per ring port, each able to cut its port off the ring.
// - each switch output belongs to exactly one port and opening it cuts only that port.
// - losing the controller heartbeat starts the isolation routine, but only while the routine is enabled.
// - entering isolation opens one port's switch and listens only on the port still connected.
// - with no heartbeat on the connected side the node reconnects it, opens the other port and listens there.
// - the node keeps alternating until a heartbeat is found or two hours of isolation have passed in total.
// - when the two hours expire both switches close and the routine is disabled.
// - after a timeout disable the routine is enabled again as soon as a heartbeat is received.
// - on a single break the nodes next to it keep the broken side open so traffic flows the other way.
// - the node sends its status report to the controller periodically in normal operation.
// - alarm and fault changes reach the controller within the update interval of one to three seconds.
package lfi_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    // heartbeat period and loss threshold
    localparam int unsigned HB_PERIOD_MS = 1000;
    localparam int unsigned HB_MISS_LIMIT = 3;
    // listen dwell per side
    localparam int unsigned DWELL_MS = 2000;
    // cumulative isolation timeout, two hours
    localparam int unsigned ISO_TIMEOUT_S = 7200;
    // status report period and alarm update interval (1 s smallest ring, 3 s largest)
    localparam int unsigned STATUS_PERIOD_MS = 1000;
    localparam int unsigned UPDATE_MIN_S = 1;
    localparam int unsigned UPDATE_MAX_S = 3;
    // derived cycle counts
    localparam longint unsigned HB_PERIOD_CYC = longint'(HB_PERIOD_MS) * CLK_HZ / 1000;
    localparam longint unsigned DWELL_CYC = longint'(DWELL_MS) * CLK_HZ / 1000;
    localparam longint unsigned STATUS_CYC = longint'(STATUS_PERIOD_MS) * CLK_HZ / 1000;
    localparam longint unsigned UPDATE_MAX_CYC = longint'(UPDATE_MAX_S) * CLK_HZ;
    localparam longint unsigned SEC_CYC = CLK_HZ;
    // port indices
    localparam int unsigned PORT_A = 0;
    localparam int unsigned PORT_B = 1;
    localparam int unsigned N_PORTS = 2;
    // reset value of the enable
    localparam logic ISO_EN_RESET = 1'b1;

    typedef enum logic [1:0] {
        LFI_NORMAL,
        LFI_LISTEN_A,
        LFI_LISTEN_B,
        LFI_HOLD
    } lfi_state_t;
endpackage

// [hw/lfi_tick_if.sv]
// carrier for the periodic ticks between the timer and the sequencer
`timescale 1ns/10ps
interface lfi_tick_if;
    logic sec_tick;
    logic status_tick;
    modport timer (output sec_tick, output status_tick);
    modport user (input sec_tick, input status_tick);
endinterface

// [hw/lfi_timer.sv]
// free running prescaler giving one second and status report ticks
`timescale 1ns/10ps
module lfi_timer
    import lfi_pkg::*;
#(
    parameter longint unsigned SEC_CYCLES = SEC_CYC,
    parameter longint unsigned STATUS_CYCLES = STATUS_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    lfi_tick_if.timer ticks
);
    logic [31:0] sec_cnt_reg;
    logic [31:0] stat_cnt_reg;

    // one second prescaler
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sec_cnt_reg <= 32'h0;
        end else if (clk_en) begin
            if (sec_cnt_reg >= 32'(SEC_CYCLES - 1)) begin
                sec_cnt_reg <= 32'h0;
            end else begin
                sec_cnt_reg <= sec_cnt_reg + 32'h1;
            end
        end
    end

    // status report prescaler
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stat_cnt_reg <= 32'h0;
        end else if (clk_en) begin
            if (stat_cnt_reg >= 32'(STATUS_CYCLES - 1)) begin
                stat_cnt_reg <= 32'h0;
            end else begin
                stat_cnt_reg <= stat_cnt_reg + 32'h1;
            end
        end
    end

    // ticks are qualified by the enable so a frozen block sees none
    assign ticks.sec_tick = clk_en && (sec_cnt_reg == 32'(SEC_CYCLES - 1));
    assign ticks.status_tick = clk_en && (stat_cnt_reg == 32'(STATUS_CYCLES - 1));
endmodule

// [verif/lfi_ctrl_model.sv]
// behavioural model of the loop controller broadcasting its heartbeat both ways
`timescale 1ns/10ps
module lfi_ctrl_model #(
    parameter int PERIOD = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic cut_a,
    input wire logic cut_b,
    output logic hb_a,
    output logic hb_b
);
    int cnt_reg;

    // broadcast period counter, never pauses while the controller runs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= 0;
        end else begin
            cnt_reg <= (cnt_reg == PERIOD - 1) ? 0 : cnt_reg + 1;
        end
    end

    // one beat per period in both ring directions; a broken wire carries nothing
    // lines sit low through reset; the beat also stands for the once a second time broadcast
    always @(posedge clock) begin
        hb_a <= #1 reset_n && cnt_reg == 0 && !cut_a;
        hb_b <= #1 reset_n && cnt_reg == 0 && !cut_b;
    end
endmodule

// [verif/tb_top.sv]
// self-checking bench for the ring isolation sequencer
`timescale 1ns/10ps
module tb_top;
    import lfi_pkg::*;
    localparam int HB_P = 20;
    localparam int DW = 10;
    localparam int SECC = 5;
    localparam int TOUT = 8;
    localparam int STAT = 50;
    localparam int F_ACT = 0;
    localparam int F_EN = 1;
    localparam int F_LOST = 2;
    localparam int F_STAT = 3;
    localparam int F_ALM = 4;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic alarm_change = 1'b0;
    logic send_ack = 1'b0;
    logic cut_a = 1'b0;
    logic cut_b = 1'b0;
    logic hb_rx_a, hb_rx_b, iso_active, iso_enabled, hb_lost, status_send, alarm_send;
    logic [1:0] iso_open;
    wire [4:0] flags = {alarm_send, status_send, hb_lost, iso_enabled, iso_active};
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    always #50 clock = ~clock;

    lfi_ctrl_model #(.PERIOD(4)) lfi_ctrl_model_inst (.clock(clock), .reset_n(reset_n), .cut_a(cut_a),
        .cut_b(cut_b), .hb_a(hb_rx_a), .hb_b(hb_rx_b));

    lfi_sequencer #(.HB_PERIOD_CYCLES(HB_P), .HB_MISS(2), .DWELL_CYCLES(DW), .TIMEOUT_SECONDS(TOUT),
        .SEC_CYCLES(SECC), .STATUS_CYCLES(STAT)) lfi_sequencer_inst (.clock(clock), .reset_n(reset_n),
        .clk_en(clk_en), .hb_rx_a(hb_rx_a), .hb_rx_b(hb_rx_b), .alarm_change(alarm_change),
        .iso_open(iso_open), .iso_active(iso_active), .iso_enabled(iso_enabled), .hb_lost(hb_lost),
        .status_send(status_send), .alarm_send(alarm_send), .send_ack(send_ack));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard; the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // every bench action lands one step after the rising edge
    task automatic tick(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check(string name, logic [1:0] exp, logic [1:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic wait_open(logic [1:0] v, int max);
        for (int i = 0; i < max && iso_open !== v; i++) tick(1);
    endtask

    task automatic wait_flag(int idx, logic v, int max);
        for (int i = 0; i < max && flags[idx] !== v; i++) tick(1);
    endtask

    task automatic t_reset;
        tick(1);
        check("iso_open", 2'b00, iso_open);
        check("iso_enabled", 1'b1, iso_enabled);
        check("hb_lost", 1'b0, hb_lost);
        check("alarm_send", 1'b0, alarm_send);
    endtask

    // periodic status, alarm report, and set winning over a same-cycle ack
    task automatic t_report;
        wait_flag(F_STAT, 1'b1, STAT + 5);
        check("status_send", 1'b1, status_send);
        send_ack = 1'b1;
        tick(1);
        send_ack = 1'b0;
        check("status_send", 1'b0, status_send);
        alarm_change = 1'b1;
        tick(1);
        check("alarm_send", 1'b1, alarm_send);
        send_ack = 1'b1;
        tick(1);
        alarm_change = 1'b0;
        check("alarm_send", 1'b1, alarm_send);
        tick(1);
        send_ack = 1'b0;
        check("alarm_send", 1'b0, alarm_send);
        check("hb_lost", 1'b0, hb_lost);
    endtask

    // total loss: alternate until the cumulative timeout, then re-enable on a beat
    task automatic t_timeout;
        int t0;
        cut_a = 1'b1;
        cut_b = 1'b1;
        t0 = cyc;
        wait_flag(F_LOST, 1'b1, 3 * HB_P + 10);
        check("hb_lost", 1'b1, hb_lost);
        check("loss not early", 1'b1, (cyc - t0) >= HB_P);
        wait_open(2'b10, 3);
        check("iso_open", 2'b10, iso_open);
        check("iso_active", 1'b1, iso_active);
        clk_en = 1'b0;
        tick(3 * DW);
        check("iso_open frozen", 2'b10, iso_open);
        clk_en = 1'b1;
        wait_open(2'b01, DW + 3);
        check("iso_open", 2'b01, iso_open);
        wait_open(2'b10, DW + 3);
        check("iso_open", 2'b10, iso_open);
        wait_open(2'b00, TOUT * SECC + 10);
        check("iso_open", 2'b00, iso_open);
        check("iso_enabled", 1'b0, iso_enabled);
        tick(4 * HB_P);
        check("iso_active", 1'b0, iso_active);
        check("iso_open", 2'b00, iso_open);
        cut_b = 1'b0;
        wait_flag(F_EN, 1'b1, 10);
        check("iso_enabled", 1'b1, iso_enabled);
        cut_a = 1'b0;
        tick(2 * HB_P);
    endtask

    // break toward port B healed while B is open: beat there ignored until B is listened on
    task automatic t_single_break;
        cut_a = 1'b1;
        cut_b = 1'b1;
        wait_open(2'b10, 4 * HB_P);
        check("iso_open", 2'b10, iso_open);
        cut_b = 1'b0;
        tick(DW / 2);
        check("iso_active", 1'b1, iso_active);
        wait_open(2'b01, DW + 3);
        check("iso_open", 2'b01, iso_open);
        wait_flag(F_ACT, 1'b0, 10);
        check("iso_active", 1'b0, iso_active);
        tick(6 * HB_P);
        check("iso_open", 2'b01, iso_open);
        check("iso_enabled", 1'b1, iso_enabled);
        // losing the far side again restarts alternation from port a
        cut_b = 1'b1;
        wait_open(2'b10, 3 * HB_P + 10);
        check("iso_open", 2'b10, iso_open);
        check("iso_active", 1'b1, iso_active);
    endtask

    initial begin
        tick(12);
        reset_n = 1'b1;
        t_reset();
        t_report();
        t_timeout();
        t_single_break();
        end_of_test();
    end
endmodule
